// ---- core/scrb_pkg.sv ----
/*
 * constants, register map and types of the serial configuration register bank.
 * assumes nothing of its surroundings; imported by the bank module.
 */
package scrb_pkg;

    // ****************************************
    // register offsets (15-bit serial address)
    // ****************************************
    localparam logic [14:0] SCRB_ADDR_INTF = 15'h0000;
    localparam logic [14:0] SCRB_ADDR_CHIP = 15'h0003;
    localparam logic [14:0] SCRB_ADDR_PROD_LO = 15'h0004;
    localparam logic [14:0] SCRB_ADDR_PROD_HI = 15'h0005;
    localparam logic [14:0] SCRB_ADDR_GRADE = 15'h0006;
    localparam logic [14:0] SCRB_ADDR_PAGE = 15'h0008;
    localparam logic [14:0] SCRB_ADDR_PWR = 15'h0011;
    localparam logic [14:0] SCRB_ADDR_TEST = 15'h0520;
    localparam logic [14:0] SCRB_ADDR_CI_LO = 15'h0521;
    localparam logic [14:0] SCRB_ADDR_CI_HI = 15'h0522;
    localparam logic [14:0] SCRB_ADDR_CQ_LO = 15'h0523;
    localparam logic [14:0] SCRB_ADDR_CQ_HI = 15'h0524;

    // ****************************************
    // field positions
    // ****************************************
    localparam int SCRB_BIT_SOFT_RESET = 0;
    localparam int SCRB_BIT_ORDER = 1;
    localparam int SCRB_BIT_ADDR_DIR = 2;
    localparam int SCRB_BIT_SDO_EN = 3;
    localparam int SCRB_BIT_TEST_MODE = 1;
    localparam int SCRB_BIT_REF_PD = 7;
    localparam int SCRB_PWR_LSB = 3;

    // ****************************************
    // reset values
    // ****************************************
    localparam logic [2:0] SCRB_INTF_RST = 3'h0;
    localparam logic [1:0] SCRB_PAGE_RST = 2'h3;
    localparam logic [4:0] SCRB_PWR_RST = 5'h1f;
    localparam logic [7:0] SCRB_TEST_RST = 8'h1c;
    localparam logic [15:0] SCRB_CONST_RST = 16'h0000;

    // identification defaults: values are arbitrary
    localparam logic [7:0] SCRB_CHIP_DEF = 8'h3c;
    localparam logic [7:0] SCRB_PROD_LO_DEF = 8'ha5;
    localparam logic [7:0] SCRB_PROD_HI_DEF = 8'h6e;
    localparam logic [3:0] SCRB_GRADE_DEF = 4'h2;
    localparam logic [3:0] SCRB_REV_DEF = 4'h1;

    // ****************************************
    // timing and framing
    // ****************************************
    localparam int SCRB_SOFT_RESET_CYCLES = 16;
    localparam logic [3:0] SCRB_INSTR_LAST = 4'hf;
    localparam logic [3:0] SCRB_BYTE_LAST = 4'h7;

    typedef enum logic {SCRB_ST_INSTR, SCRB_ST_DATA} scrb_state_t;

endpackage

// ---- core/scrb_spi_config_regs.sv ----
/*
 * serial-port configuration and identification register bank with its spi slave.
 * assumes sclk at most one eighth of i_clk, spi mode 0, and that link, converter
 * and reference logic consume the control outputs.
 */
`timescale 1ns/1ps
// Overview of operation
// - writing soft reset bit starts self-clearing reset
// - streaming address counts up or down by bit
// - bit order selects lsb or msb first
// - page pointer routes to link a, b, both
// - reference power-down bit forces reference off
module scrb_spi_config_regs
#(
    parameter int SOFT_RESET_CYCLES = scrb_pkg::SCRB_SOFT_RESET_CYCLES,
    parameter logic [7:0] CHIP_CATEGORY = scrb_pkg::SCRB_CHIP_DEF,
    parameter logic [7:0] PRODUCT_CODE_LOW = scrb_pkg::SCRB_PROD_LO_DEF,
    parameter logic [7:0] PRODUCT_CODE_HIGH = scrb_pkg::SCRB_PROD_HI_DEF,
    parameter logic [3:0] PRODUCT_GRADE = scrb_pkg::SCRB_GRADE_DEF,
    parameter logic [3:0] SILICON_REVISION = scrb_pkg::SCRB_REV_DEF
)
(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // serial pins
    input wire logic i_spi_sclk,
    input wire logic i_spi_csb_n,
    input wire logic i_spi_sdio,
    output logic o_spi_sdio,
    output logic o_spi_sdio_oe,
    output logic o_spi_sdo,
    output logic o_spi_sdo_oe,
    // control outputs
    output logic o_soft_reset,
    output logic o_link_a_select,
    output logic o_link_b_select,
    output logic o_reference_power_down,
    output logic [3:0] o_dac_power_down,
    output logic o_constant_output_test_mode,
    output logic [15:0] o_constant_i,
    output logic [15:0] o_constant_q
);
    import scrb_pkg::*;

    // ****************************************
    // parameter checks
    // ****************************************
    generate
        if (SOFT_RESET_CYCLES < 1 || SOFT_RESET_CYCLES > 255)
        begin : g_bad_reset_len
            $error("SOFT_RESET_CYCLES must lie in 1..255");
        end
    endgenerate

    localparam logic [7:0] SRST_LOAD = 8'(SOFT_RESET_CYCLES);

    // ****************************************
    // pin synchronisers
    // ****************************************
    // third sclk stage only feeds edge detection; stage 0 feeds stage 1 alone
    logic [2:0] sclk_s_q;
    logic [1:0] csb_s_q;
    logic [1:0] sdio_s_q;

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            sclk_s_q <= 3'h0;
            csb_s_q <= 2'h3;
            sdio_s_q <= 2'h0;
        end
        else
        begin
            sclk_s_q <= {sclk_s_q[1:0], i_spi_sclk};
            csb_s_q <= {csb_s_q[0], i_spi_csb_n};
            sdio_s_q <= {sdio_s_q[0], i_spi_sdio};
        end
    end

    logic sclk_rise;
    logic sclk_fall;
    logic selected;
    logic in_bit;
    assign sclk_rise = sclk_s_q[1] & ~sclk_s_q[2];
    assign sclk_fall = ~sclk_s_q[1] & sclk_s_q[2];
    assign selected = ~csb_s_q[1];
    assign in_bit = sdio_s_q[1];

    // ****************************************
    // register state
    // ****************************************
    logic [2:0] intf_q, intf_d;
    logic [7:0] srst_cnt_q, srst_cnt_d;
    logic srst_q, srst_d;
    logic [1:0] page_q, page_d;
    logic [4:0] pwr_q, pwr_d;
    logic [7:0] test_q, test_d;
    logic [15:0] ci_q, ci_d;
    logic [15:0] cq_q, cq_d;

    logic lsb_first;
    logic addr_up;
    logic sdo_en;
    assign lsb_first = intf_q[SCRB_BIT_ORDER - 1];
    assign addr_up = intf_q[SCRB_BIT_ADDR_DIR - 1];
    assign sdo_en = intf_q[SCRB_BIT_SDO_EN - 1];

    function automatic logic [7:0] read_reg(input logic [14:0] a);
        logic [7:0] v;
        v = 8'h00;
        case (a)
            SCRB_ADDR_INTF: v = {srst_q, intf_q[0], intf_q[1], intf_q[2], intf_q, srst_q};
            SCRB_ADDR_CHIP: v = CHIP_CATEGORY;
            SCRB_ADDR_PROD_LO: v = PRODUCT_CODE_LOW;
            SCRB_ADDR_PROD_HI: v = PRODUCT_CODE_HIGH;
            SCRB_ADDR_GRADE: v = {PRODUCT_GRADE, SILICON_REVISION};
            SCRB_ADDR_PAGE: v = {6'h00, page_q};
            SCRB_ADDR_PWR: v = {pwr_q, 3'h0};
            SCRB_ADDR_TEST: v = test_q;
            SCRB_ADDR_CI_LO: v = ci_q[7:0];
            SCRB_ADDR_CI_HI: v = ci_q[15:8];
            SCRB_ADDR_CQ_LO: v = cq_q[7:0];
            SCRB_ADDR_CQ_HI: v = cq_q[15:8];
            default: v = 8'h00;
        endcase
        return v;
    endfunction

    // ****************************************
    // serial engine
    // ****************************************
    scrb_state_t state_q, state_d;
    logic [3:0] cnt_q, cnt_d;
    logic [15:0] shift_q, shift_d;
    logic [14:0] addr_q, addr_d;
    logic rd_q, rd_d;
    logic [7:0] tx_q, tx_d;
    logic sdo_q, sdo_d;
    logic out_en_q, out_en_d;
    logic wr_en;
    logic [14:0] wr_addr;
    logic [7:0] wr_data;

    always_comb
    begin
        state_d = state_q;
        cnt_d = cnt_q;
        shift_d = shift_q;
        addr_d = addr_q;
        rd_d = rd_q;
        tx_d = tx_q;
        sdo_d = sdo_q;
        out_en_d = out_en_q;
        wr_en = 1'b0;
        wr_addr = addr_q;
        wr_data = 8'h00;
        if (!selected)
        begin
            state_d = SCRB_ST_INSTR;
            cnt_d = 4'h0;
            out_en_d = 1'b0;
        end
        else if (sclk_rise)
        begin
            case (state_q)
                SCRB_ST_INSTR:
                begin
                    // instruction is always msb first: read flag then address
                    shift_d = {shift_q[14:0], in_bit};
                    cnt_d = cnt_q + 4'h1;
                    if (cnt_q == SCRB_INSTR_LAST)
                    begin
                        rd_d = shift_d[15];
                        addr_d = shift_d[14:0];
                        state_d = SCRB_ST_DATA;
                        cnt_d = 4'h0;
                        out_en_d = shift_d[15];
                        tx_d = read_reg(shift_d[14:0]);
                    end
                end
                SCRB_ST_DATA:
                begin
                    if (lsb_first)
                        shift_d[7:0] = {in_bit, shift_q[7:1]};
                    else
                        shift_d[7:0] = {shift_q[6:0], in_bit};
                    cnt_d = cnt_q + 4'h1;
                    if (cnt_q == SCRB_BYTE_LAST)
                    begin
                        cnt_d = 4'h0;
                        wr_en = ~rd_q;
                        wr_data = shift_d[7:0];
                        addr_d = addr_up ? addr_q + 15'h0001 : addr_q - 15'h0001;
                        tx_d = read_reg(addr_d);
                    end
                end
                default: state_d = SCRB_ST_INSTR;
            endcase
        end
        else if (sclk_fall && out_en_q)
        begin
            sdo_d = lsb_first ? tx_q[0] : tx_q[7];
            tx_d = lsb_first ? {1'b0, tx_q[7:1]} : {tx_q[6:0], 1'b0};
        end
    end

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            state_q <= SCRB_ST_INSTR;
            cnt_q <= 4'h0;
            shift_q <= 16'h0000;
            addr_q <= 15'h0000;
            rd_q <= 1'b0;
            tx_q <= 8'h00;
            sdo_q <= 1'b0;
            out_en_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            shift_q <= shift_d;
            addr_q <= addr_d;
            rd_q <= rd_d;
            tx_q <= tx_d;
            sdo_q <= sdo_d;
            out_en_q <= out_en_d;
        end
    end

    // ****************************************
    // register writes and soft reset
    // ****************************************
    // writes landing while the soft reset runs are dropped, since it restores defaults
    always_comb
    begin
        intf_d = intf_q;
        srst_cnt_d = srst_cnt_q;
        page_d = page_q;
        pwr_d = pwr_q;
        test_d = test_q;
        ci_d = ci_q;
        cq_d = cq_q;
        if (srst_q)
        begin
            srst_cnt_d = srst_cnt_q - 8'h01;
            intf_d = SCRB_INTF_RST;
            page_d = SCRB_PAGE_RST;
            pwr_d = SCRB_PWR_RST;
            test_d = SCRB_TEST_RST;
            ci_d = SCRB_CONST_RST;
            cq_d = SCRB_CONST_RST;
        end
        else if (wr_en)
        begin
            case (wr_addr)
                SCRB_ADDR_INTF:
                begin
                    if (wr_data[SCRB_BIT_SOFT_RESET])
                        srst_cnt_d = SRST_LOAD;
                    else
                        intf_d = wr_data[SCRB_BIT_SDO_EN:SCRB_BIT_ORDER];
                end
                SCRB_ADDR_PAGE: page_d = wr_data[1:0];
                SCRB_ADDR_PWR: pwr_d = wr_data[7:SCRB_PWR_LSB];
                SCRB_ADDR_TEST: test_d = wr_data;
                SCRB_ADDR_CI_LO: ci_d[7:0] = wr_data;
                SCRB_ADDR_CI_HI: ci_d[15:8] = wr_data;
                SCRB_ADDR_CQ_LO: cq_d[7:0] = wr_data;
                SCRB_ADDR_CQ_HI: cq_d[15:8] = wr_data;
                default: ;
            endcase
        end
        srst_d = (srst_cnt_d != 8'h00);
    end

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            intf_q <= SCRB_INTF_RST;
            srst_cnt_q <= 8'h00;
            srst_q <= 1'b0;
            page_q <= SCRB_PAGE_RST;
            pwr_q <= SCRB_PWR_RST;
            test_q <= SCRB_TEST_RST;
            ci_q <= SCRB_CONST_RST;
            cq_q <= SCRB_CONST_RST;
        end
        else
        begin
            intf_q <= intf_d;
            srst_cnt_q <= srst_cnt_d;
            srst_q <= srst_d;
            page_q <= page_d;
            pwr_q <= pwr_d;
            test_q <= test_d;
            ci_q <= ci_d;
            cq_q <= cq_d;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign o_spi_sdio = sdo_q;
    assign o_spi_sdo = sdo_q;
    assign o_spi_sdio_oe = out_en_q & ~sdo_en;
    assign o_spi_sdo_oe = out_en_q & sdo_en;
    assign o_soft_reset = srst_q;
    assign o_link_a_select = page_q[0];
    assign o_link_b_select = page_q[1];
    assign o_reference_power_down = pwr_q[SCRB_BIT_REF_PD - SCRB_PWR_LSB];
    assign o_dac_power_down = {pwr_q[0], pwr_q[1], pwr_q[2], pwr_q[3]};
    assign o_constant_output_test_mode = test_q[SCRB_BIT_TEST_MODE];
    assign o_constant_i = ci_q;
    assign o_constant_q = cq_q;

endmodule

// ---- testbench/scrb_monitor.sv ----
/* port checker for the serial config register bank.
   assumes it is bound onto the bank; one clock domain. */
`timescale 1ns/1ps
module scrb_monitor
#(
    parameter int SOFT_RESET_CYCLES = 16
)
(
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_spi_csb_n,
    input wire logic o_spi_sdio_oe,
    input wire logic o_spi_sdo_oe,
    input wire logic o_soft_reset,
    input wire logic o_link_a_select,
    input wire logic o_link_b_select,
    input wire logic o_reference_power_down,
    input wire logic [3:0] o_dac_power_down,
    input wire logic [15:0] o_constant_i,
    input wire logic [15:0] o_constant_q
);
    // ****************
    // assertions
    // ****************
    int cnt_q;
    int cnt_d;
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);
    // counts how long the soft reset has been held
    always_comb cnt_d = o_soft_reset ? cnt_q + 1 : 0;
    always_ff @(posedge i_clk or posedge i_rst)
        if (i_rst) cnt_q <= 0;
        else cnt_q <= cnt_d;
    reset_defaults_a: assert property ($fell(i_rst) |-> o_link_a_select && o_link_b_select
        && o_reference_power_down && o_dac_power_down == 4'hf && !o_soft_reset) else $error("bad reset values");
    soft_length_a: assert property ($fell(o_soft_reset) |-> cnt_q == SOFT_RESET_CYCLES)
        else $error("soft reset length wrong");
    soft_bound_a: assert property (o_soft_reset |-> cnt_q < SOFT_RESET_CYCLES)
        else $error("soft reset too long");
    soft_cause_a: assert property ($rose(o_soft_reset) |-> $past(i_spi_csb_n, 6) == 1'b0)
        else $error("soft reset without a frame");
    soft_defaults_a: assert property (o_soft_reset && $past(o_soft_reset) |-> o_link_a_select
        && o_link_b_select && o_reference_power_down && o_constant_i == 16'h0000 && o_constant_q == 16'h0000
        && o_dac_power_down == 4'hf) else $error("not at defaults");
    oe_release_a: assert property ($rose(i_spi_csb_n) |-> ##[1:6] !o_spi_sdio_oe && !o_spi_sdo_oe)
        else $error("output enable stuck");
    oe_one_pin_a: assert property (o_spi_sdo_oe |-> !o_spi_sdio_oe)
        else $error("both pins driven");
    ctrl_hold_a: assert property (!$stable({o_reference_power_down, o_link_b_select, o_link_a_select})
        |-> $past(i_spi_csb_n, 2) == 1'b0 || o_soft_reset || $past(o_soft_reset)) else $error("stray change");
    cover property ($fell(o_soft_reset));
    cover property ($rose(o_spi_sdo_oe));
    cover property ($fell(o_link_b_select));
endmodule
bind scrb_spi_config_regs scrb_monitor #(.SOFT_RESET_CYCLES(SOFT_RESET_CYCLES)) u_mon (.i_clk(i_clk),
    .i_rst(i_rst), .i_spi_csb_n(i_spi_csb_n), .o_spi_sdio_oe(o_spi_sdio_oe), .o_spi_sdo_oe(o_spi_sdo_oe),
    .o_soft_reset(o_soft_reset), .o_link_a_select(o_link_a_select), .o_link_b_select(o_link_b_select),
    .o_reference_power_down(o_reference_power_down), .o_dac_power_down(o_dac_power_down),
    .o_constant_i(o_constant_i), .o_constant_q(o_constant_q));

// ---- testbench/scrb_spi_host.sv ----
/* behavioural serial host for the config bank, mode 0.
   assumes the bench resolves the shared data wire. */
`timescale 1ns/1ps
module scrb_spi_host
(
    input wire logic i_clk,
    input wire logic i_sdio_w,
    input wire logic i_sdo,
    input wire logic i_sdo_oe,
    output logic o_sclk,
    output logic o_csb_n,
    output logic o_sdio,
    output logic o_rd_done,
    output logic [7:0] o_rd_q
);
    // ****************
    // bit and frame
    // ****************
    initial
    begin
        o_sclk = 1'b0;
        o_csb_n = 1'b1;
        o_sdio = 1'b0;
        o_rd_done = 1'b0;
        o_rd_q = 8'h00;
    end
    // six clocks a half period: read data lands 3-4 clocks after the fall
    task automatic bit_io(input logic b, output logic s);
        o_sdio <= b;
        repeat (6) @(posedge i_clk);
        s = i_sdo_oe ? i_sdo : i_sdio_w;
        o_sclk <= 1'b1;
        repeat (6) @(posedge i_clk);
        o_sclk <= 1'b0;
    endtask
    task automatic xfer(input logic rd, input logic [14:0] a, input logic [31:0] d, input int n, input logic lsb);
        logic [15:0] ins;
        logic [7:0] q;
        logic s;
        ins = {rd, a};
        q = 8'h00;
        o_csb_n <= 1'b0;
        repeat (4) @(posedge i_clk);
        for (int i = 15; i >= 0; i--) bit_io(ins[i], s);
        for (int k = 0; k < n; k++)
            for (int i = 0; i < 8; i++)
            begin
                // released line flips so stale data never passes
                bit_io(rd ? ~o_sdio : d[8 * k + (lsb ? i : 7 - i)], s);
                q[lsb ? i : 7 - i] = s;
            end
        repeat (6) @(posedge i_clk);
        o_csb_n <= 1'b1;
        o_sdio <= ~o_sdio;
        o_rd_q <= q;
        o_rd_done <= rd;
        @(posedge i_clk);
        o_rd_done <= 1'b0;
        repeat (4) @(posedge i_clk);
    endtask
endmodule

// ---- testbench/tb_spi_config_register_bank.sv ----
/* self-checking bench of the config register bank.
   assumes the host model and the bound checker. */
`timescale 1ns/1ps
module tb_spi_config_register_bank;
    import scrb_pkg::*;
    localparam int SRC = 5;
    logic clk, rst, sclk, csb_n, h_sdio, d_sdio, d_sdio_oe, d_sdo, d_sdo_oe, sr, la, lb, rpd, tm, done, lsb;
    logic [3:0] dpd;
    logic [15:0] ci, cq;
    logic [7:0] rd_q;
    logic [31:0] r;
    logic [7:0] exp_q[$];
    wire logic sdio_w;
    int error_cnt, samples_checked, sr_seen, seed;
    assign sdio_w = d_sdio_oe ? d_sdio : h_sdio;
    scrb_spi_config_regs #(.SOFT_RESET_CYCLES(SRC)) DUT (.i_clk(clk), .i_rst(rst), .i_spi_sclk(sclk),
        .i_spi_csb_n(csb_n), .i_spi_sdio(sdio_w), .o_spi_sdio(d_sdio), .o_spi_sdio_oe(d_sdio_oe),
        .o_spi_sdo(d_sdo), .o_spi_sdo_oe(d_sdo_oe), .o_soft_reset(sr), .o_link_a_select(la),
        .o_link_b_select(lb), .o_reference_power_down(rpd), .o_dac_power_down(dpd),
        .o_constant_output_test_mode(tm), .o_constant_i(ci), .o_constant_q(cq));
    scrb_spi_host host (.i_clk(clk), .i_sdio_w(sdio_w), .i_sdo(d_sdo), .i_sdo_oe(d_sdo_oe), .o_sclk(sclk),
        .o_csb_n(csb_n), .o_sdio(h_sdio), .o_rd_done(done), .o_rd_q(rd_q));
    // ****************
    // tasks
    // ****************
    task chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task wr(input logic [14:0] a, input logic [31:0] d, input int n);
        host.xfer(1'b0, a, d, n, lsb);
    endtask
    task rd(input logic [14:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        host.xfer(1'b1, a, 32'h0, 1, lsb);
    endtask
    task print_verdict();
        $display("checks %0d errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // ****************
    // processes
    // ****************
    always #25 clk = ~clk;
    always @(posedge clk) if (sr === 1'b1) sr_seen++;
    always @(posedge clk)
        if (done === 1'b1)
        begin
            if (exp_q.size() == 0) chk(32'h1, 32'h0);
            else chk({24'h0, rd_q}, {24'h0, exp_q.pop_front()});
        end
    initial
    begin
        repeat (100000) @(posedge clk);
        error_cnt++;
        print_verdict();
    end
    initial
    begin
        clk = 1'b0;
        rst = 1'b1;
        lsb = 1'b0;
        seed = 32'h6a4ce992;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
        chk({lb, la, rpd, dpd, sr, tm}, 32'h1fc);
        rd(SCRB_ADDR_INTF, 8'h00);
        rd(SCRB_ADDR_PAGE, 8'h03);
        rd(SCRB_ADDR_PWR, 8'hf8);
        rd(SCRB_ADDR_TEST, 8'h1c);
        wr(SCRB_ADDR_CHIP, 32'hff, 1);
        rd(SCRB_ADDR_CHIP, SCRB_CHIP_DEF);
        rd(15'h0100, 8'h00);
        for (int p = 3; p > 0; p--)
        begin
            wr(SCRB_ADDR_PAGE, 32'(p), 1);
            chk({lb, la}, 32'(p));
            rd(SCRB_ADDR_PAGE, 8'(p));
        end
        wr(SCRB_ADDR_PWR, 32'h00, 1);
        chk(rpd, 32'h0);
        wr(SCRB_ADDR_PWR, 32'h80, 1);
        chk(rpd, 32'h1);
        chk(dpd, 32'h0);
        wr(SCRB_ADDR_INTF, 32'h04, 1);
        rd(SCRB_ADDR_INTF, 8'h24);
        r = $random(seed);
        wr(SCRB_ADDR_CI_LO, r, 4);
        chk({cq, ci}, r);
        wr(SCRB_ADDR_INTF, 32'h00, 1);
        r = $random(seed);
        wr(SCRB_ADDR_CQ_HI, r, 4);
        chk({cq, ci}, {r[7:0], r[15:8], r[23:16], r[31:24]});
        wr(SCRB_ADDR_INTF, 32'h0e, 1);
        lsb = 1'b1;
        rd(SCRB_ADDR_INTF, 8'h7e);
        r = $random(seed);
        wr(SCRB_ADDR_CI_HI, r, 1);
        chk(ci[15:8], r[7:0]);
        rd(SCRB_ADDR_CI_HI, r[7:0]);
        rd(SCRB_ADDR_TEST, 8'h1c);
        wr(SCRB_ADDR_INTF, 32'h00, 1);
        lsb = 1'b0;
        wr(SCRB_ADDR_INTF, 32'h01, 1);
        repeat (SRC + 8) @(posedge clk);
        chk(sr_seen, SRC);
        rd(SCRB_ADDR_PAGE, 8'h03);
        rd(SCRB_ADDR_PWR, 8'hf8);
        chk({cq, ci}, 32'h0);
        rd(SCRB_ADDR_INTF, 8'h00);
        wr(SCRB_ADDR_TEST, 32'h1e, 1);
        chk(tm, 32'h1);
        rd(SCRB_ADDR_TEST, 8'h1e);
        for (int i = 0; i < 100 && exp_q.size() > 0; i++) @(posedge clk);
        if (exp_q.size() > 0) error_cnt++;
        print_verdict();
    end
endmodule
